// *** common/lcaf_cfg.svh ***
// Offsets, field positions, reset values and unit lengths for the framer.
// Assumes inclusion by bare name from the framer.
`ifndef LCAF_CFG_SVH
`define LCAF_CFG_SVH
`define LCAF_OFF_CTRL 8'h00
`define LCAF_OFF_STATUS 8'h04
`define LCAF_OFF_CRC 8'h08
`define LCAF_CTRL_EN 0
`define LCAF_CTRL_IF_LO 1
`define LCAF_CTRL_ROBUST 3
`define LCAF_CTRL_GRP_LO 4
`define LCAF_CTRL_RST 8'h00
`define LCAF_RESP_OKAY 2'h0
`define LCAF_RESP_SLVERR 2'h2
`define LCAF_ID_BITS 14
`define LCAF_DL_RSV_BITS 7
`define LCAF_DL_PRE_LEN 8'h7c
`define LCAF_DL_CODED_NORMAL 8'ha8
`define LCAF_DL_CODED_ROBUST 8'hfc
`define LCAF_UL_PRE_LEN 8'h88
`define LCAF_UL_CODED 8'hb0
`define LCAF_UL_HALF_LEN 8'h4c
`define LCAF_UL_FIRST_BITS 75
`define LCAF_UL_LAST_BITS 61
`define LCAF_ACK_MSG_BITS 21
`define LCAF_ACK_GRP_BITS 23
`define LCAF_ACK_LONG_MSGS 6
`define LCAF_ACK_SHORT_MSGS 2
`define LCAF_ACK_LONG_LEN 8'h8f
`define LCAF_ACK_SHORT_LEN 8'h33
`define LCAF_ACK_CODED 8'haf
`define LCAF_CRC_INIT 14'h3fff
`define LCAF_CRC_POLY 14'h0443
`endif

// *** common/lcaf_pkg.sv ***
// Types shared by the framer and its surroundings.
// Assumes the configuration header is on the include path.
package lcaf_pkg;
    typedef enum logic [2:0] {
        LCAF_IDLE = 3'h1,
        LCAF_EMIT = 3'h2,
        LCAF_EMIT2 = 3'h4
    } lcaf_state_type;
    typedef enum logic [1:0] {
        LCAF_IF_MAIN_DL = 2'h0,
        LCAF_IF_SECONDARY = 2'h1,
        LCAF_IF_UPLINK = 2'h2
    } lcaf_iface_type;
    typedef enum logic [1:0] {
        LCAF_UNIT_CONN = 2'h0,
        LCAF_UNIT_ACK_LONG = 2'h1,
        LCAF_UNIT_ACK_SHORT = 2'h2
    } lcaf_unit_kind_type;
    typedef enum logic [1:0] {
        LCAF_REPLY_L2_L3 = 2'h0,
        LCAF_REPLY_L2_ONLY = 2'h1,
        LCAF_REPLY_L3_ONLY = 2'h2,
        LCAF_REPLY_L3_CONFIRM = 2'h3
    } lcaf_reply_type;
    typedef struct packed {
        logic [13:0] link_identifier;
        lcaf_reply_type category;
        logic [4:0] sequence_block_index;
    } lcaf_ack_msg_type;
    typedef struct packed {
        lcaf_unit_kind_type kind;
        logic [130:0] bits;
    } lcaf_unit_type;
    typedef struct packed {
        logic [142:0] bits;
        logic [7:0] pre_len;
        logic [7:0] coded_len;
        logic half;
    } lcaf_block_type;
endpackage

// *** design/lcaf_framer.sv ***
// Framer that packs connection and acknowledge units into pre-coding blocks.
// Assumes layer-2 logic and the block encoder share ref_clk_in.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcaf_cfg.svh"

module lcaf_framer (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire lcaf_pkg::lcaf_unit_type unit_in,
    input wire logic unit_valid_in,
    output logic unit_ready_out,
    input wire logic pwr_reduce_policy_in,
    input wire logic robust_req_policy_in,
    output lcaf_pkg::lcaf_block_type block_out,
    output logic block_valid_out,
    input wire logic block_ready_in,
    output logic [13:0] wake_link_identifier_out,
    output logic wake_valid_out
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    typedef struct packed {
        lcaf_pkg::lcaf_state_type fsm;
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [13:0] crc_last;
        lcaf_pkg::lcaf_block_type blk;
        logic [75:0] second;
        logic split;
        logic [13:0] wake_id;
        logic wake;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lcaf_regs_type;

    lcaf_regs_type r;
    lcaf_regs_type next_r;

    // ----------------------------------------------------------------
    // Checksum over the connection unit, most significant bit first.
    // ----------------------------------------------------------------
    function automatic logic [13:0] lcaf_crc(input logic [130:0] data);
        logic [13:0] crc;
        logic fb;
        crc = `LCAF_CRC_INIT;
        for (int i = 130; i >= 0; i--) begin
            fb = crc[13] ^ data[i];
            crc = {crc[12:0], 1'b0};
            if (fb) begin
                crc = crc ^ `LCAF_CRC_POLY;
            end
        end
        return ~crc;
    endfunction

    // ----------------------------------------------------------------
    // Decoded control.
    // ----------------------------------------------------------------
    logic enable;
    logic robust;
    logic [1:0] iface;
    logic [3:0] group;
    logic main_dl;
    logic flag_pr;
    logic flag_rr;

    assign enable = r.ctrl[`LCAF_CTRL_EN];
    assign robust = r.ctrl[`LCAF_CTRL_ROBUST];
    assign iface = r.ctrl[`LCAF_CTRL_IF_LO +: 2];
    assign group = r.ctrl[`LCAF_CTRL_GRP_LO +: 4];
    assign main_dl = (iface == lcaf_pkg::LCAF_IF_MAIN_DL);
    assign flag_pr = pwr_reduce_policy_in & main_dl;
    assign flag_rr = robust_req_policy_in & main_dl;

    // ----------------------------------------------------------------
    // Handshakes.
    // ----------------------------------------------------------------
    logic unit_take;
    logic blk_take;
    logic aw_take;
    logic w_take;
    logic ar_take;

    // Only one unit is in flight, so order is kept and the next unit waits until the last block is taken.
    assign unit_ready_out = (r.fsm == lcaf_pkg::LCAF_IDLE) & enable;
    assign unit_take = unit_ready_out & unit_valid_in;
    assign block_valid_out = (r.fsm != lcaf_pkg::LCAF_IDLE);
    assign blk_take = block_valid_out & block_ready_in;
    assign block_out = r.blk;
    assign wake_link_identifier_out = r.wake_id;
    assign wake_valid_out = r.wake & block_valid_out;
    assign s_axi_awready_out = ~r.aw_held & ~r.bvalid;
    assign s_axi_wready_out = ~r.w_held & ~r.bvalid;
    assign s_axi_arready_out = ~r.rvalid;
    assign aw_take = s_axi_awready_out & s_axi_awvalid_in;
    assign w_take = s_axi_wready_out & s_axi_wvalid_in;
    assign ar_take = s_axi_arready_out & s_axi_arvalid_in;
    assign s_axi_bvalid_out = r.bvalid;
    assign s_axi_bresp_out = r.bresp;
    assign s_axi_rvalid_out = r.rvalid;
    assign s_axi_rdata_out = r.rdata;
    assign s_axi_rresp_out = r.rresp;

    // ----------------------------------------------------------------
    // Next state.
    // ----------------------------------------------------------------
    always_comb begin
        logic [135:0] ul;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [13:0] crc;
        int msgs;
        ul = '0;
        waddr = '0;
        wdata = '0;
        wstrb = '0;
        crc = '0;
        msgs = 0;
        next_r = r;

        // Register writes in the cycle that address and data are both taken or held.
        waddr = aw_take ? s_axi_awaddr_in : r.aw_addr;
        wdata = w_take ? s_axi_wdata_in : r.w_data;
        wstrb = w_take ? s_axi_wstrb_in : r.w_strb;
        if (aw_take) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr_in;
        end
        if (w_take) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata_in;
            next_r.w_strb = s_axi_wstrb_in;
        end
        if ((r.aw_held | aw_take) & (r.w_held | w_take)) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `LCAF_RESP_OKAY;
            if (waddr == `LCAF_OFF_CTRL) begin
                if (wstrb[0]) begin
                    next_r.ctrl = wdata[7:0];
                end
            end else if (waddr != `LCAF_OFF_STATUS && waddr != `LCAF_OFF_CRC) begin
                next_r.bresp = `LCAF_RESP_SLVERR;
            end
        end
        if (r.bvalid & s_axi_bready_in) begin
            next_r.bvalid = 1'b0;
        end

        // Register reads.
        if (r.rvalid & s_axi_rready_in) begin
            next_r.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = `LCAF_RESP_OKAY;
            next_r.rdata = 32'h0;
            unique case (s_axi_araddr_in)
                `LCAF_OFF_CTRL: begin
                    next_r.rdata = {24'h0, r.ctrl};
                end
                `LCAF_OFF_STATUS: begin
                    next_r.rdata = {r.count, 13'h0, r.fsm};
                end
                `LCAF_OFF_CRC: begin
                    next_r.rdata = {18'h0, r.crc_last};
                end
                default: begin
                    next_r.rresp = `LCAF_RESP_SLVERR;
                end
            endcase
        end

        // Framing.
        unique case (r.fsm)
            lcaf_pkg::LCAF_IDLE: begin
                if (unit_take) begin
                    next_r.fsm = lcaf_pkg::LCAF_EMIT;
                    next_r.blk = '0;
                    next_r.split = 1'b0;
                    next_r.wake = 1'b0;
                    next_r.wake_id = '0;
                    next_r.second = '0;
                    if (unit_in.kind == lcaf_pkg::LCAF_UNIT_CONN) begin
                        if (iface == lcaf_pkg::LCAF_IF_UPLINK) begin
                            ul = {1'b1, group, unit_in.bits};
                            if (robust) begin
                                crc = lcaf_crc(unit_in.bits);
                                next_r.crc_last = crc;
                                next_r.split = 1'b1;
                                next_r.blk.bits[142 -: 76] = {1'b0, ul[135 -: 75]};
                                next_r.second = {1'b1, crc, ul[60:0]};
                                next_r.blk.pre_len = `LCAF_UL_HALF_LEN;
                            end else begin
                                next_r.blk.bits[142 -: 136] = ul;
                                next_r.blk.pre_len = `LCAF_UL_PRE_LEN;
                            end
                            next_r.blk.coded_len = `LCAF_UL_CODED;
                        end else begin
                            // The identifier goes to the wake-up builder instead.
                            next_r.wake = 1'b1;
                            next_r.wake_id = unit_in.bits[130 -: 14];
                            next_r.blk.bits[142 -: 124] = {7'h0, unit_in.bits[116:0]};
                            next_r.blk.pre_len = `LCAF_DL_PRE_LEN;
                            next_r.blk.coded_len = robust ?
                                `LCAF_DL_CODED_ROBUST : `LCAF_DL_CODED_NORMAL;
                        end
                    end else begin
                        // Five reserved zeros lead; groups follow from bit 137 down.
                        if (unit_in.kind == lcaf_pkg::LCAF_UNIT_ACK_LONG) begin
                            msgs = `LCAF_ACK_LONG_MSGS;
                            next_r.blk.pre_len = `LCAF_ACK_LONG_LEN;
                        end else begin
                            msgs = `LCAF_ACK_SHORT_MSGS;
                            next_r.blk.pre_len = `LCAF_ACK_SHORT_LEN;
                        end
                        for (int i = 0; i < `LCAF_ACK_LONG_MSGS; i++) begin
                            if (i < msgs) begin
                                next_r.blk.bits[137 - 23 * i -: 23] = {
                                    unit_in.bits[21 * msgs - 1 - 21 * i -: 21],
                                    flag_pr,
                                    flag_rr
                                };
                            end
                        end
                        next_r.blk.coded_len = `LCAF_ACK_CODED;
                    end
                end
            end
            lcaf_pkg::LCAF_EMIT: begin
                if (blk_take) begin
                    if (r.split) begin
                        // Second half follows the first with nothing between.
                        next_r.fsm = lcaf_pkg::LCAF_EMIT2;
                        next_r.blk.bits = {r.second, 67'h0};
                        next_r.blk.half = 1'b1;
                    end else begin
                        next_r.fsm = lcaf_pkg::LCAF_IDLE;
                        next_r.count = r.count + 16'h1;
                    end
                end
            end
            lcaf_pkg::LCAF_EMIT2: begin
                if (blk_take) begin
                    next_r.fsm = lcaf_pkg::LCAF_IDLE;
                    next_r.count = r.count + 16'h1;
                end
            end
            default: begin
                next_r.fsm = lcaf_pkg::LCAF_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.fsm <= lcaf_pkg::LCAF_IDLE;
            r.ctrl <= `LCAF_CTRL_RST;
        end else begin
            r <= next_r;
        end
    end

endmodule

// *** verification/lcaf_block_sink.sv ***
// Block encoder stand-in that takes blocks, ready only one cycle in four on request.
// Assumes the framer's clock and reset.
`timescale 1ns/1ps
module lcaf_block_sink (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire lcaf_pkg::lcaf_block_type block_in,
    input wire logic block_valid_in,
    input wire logic [13:0] wake_in,
    input wire logic wake_valid_in,
    input wire logic stall_in,
    output logic block_ready_out
);
    // ----
    // Capture.
    // ----
    lcaf_pkg::lcaf_block_type got [$];
    logic [13:0] wake_seen = 14'h0;
    logic [1:0] cnt = 2'h0;
    initial block_ready_out = 1'b0;
    always @(posedge ref_clk_in) begin
        cnt <= sys_rst_in ? 2'h0 : cnt + 2'h1;
        block_ready_out <= !sys_rst_in && (!stall_in || cnt == 2'h2);
        if (!sys_rst_in && block_valid_in && block_ready_out) begin
            got.push_back(block_in);
            if (wake_valid_in) wake_seen <= wake_in;
        end
    end
endmodule

// *** verification/lcaf_framer_asserts.sv ***
// Concurrent checks on the framer's stream ports.
// Assumes binding to lcaf_framer and a single clock domain.
`timescale 1ns/1ps
module lcaf_framer_chk (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic unit_valid_in,
    input wire logic unit_ready_out,
    input wire lcaf_pkg::lcaf_block_type block_out,
    input wire logic block_valid_out,
    input wire logic block_ready_in,
    input wire logic wake_valid_out
);
    // ----
    // Properties.
    // ----
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_BLK_NEXT: assert property (unit_valid_in && unit_ready_out |=> block_valid_out)
        else $error("no block after unit");
    AST_BLK_HOLD: assert property (block_valid_out && !block_ready_in |=>
        block_valid_out && $stable(block_out)) else $error("block moved while stalled");
    AST_ONE_UNIT: assert property (block_valid_out |-> !unit_ready_out)
        else $error("unit accepted while block pending");
    AST_DL_RSV: assert property (block_valid_out && block_out.pre_len == 8'h7c |->
        block_out.bits[142:136] == 7'h0 && block_out.coded_len inside {8'ha8, 8'hfc})
        else $error("bad downlink block");
    AST_UL_TYPE: assert property (block_valid_out && block_out.pre_len == 8'h88 |->
        block_out.bits[142] && block_out.coded_len == 8'hb0) else $error("bad uplink block");
    AST_ACK_RSV: assert property (block_valid_out && block_out.coded_len == 8'haf |->
        block_out.bits[142:138] == 5'h0 && block_out.pre_len inside {8'h8f, 8'h33})
        else $error("bad ack block");
    AST_HALF_FLAG: assert property (block_valid_out && block_out.pre_len == 8'h4c |->
        block_out.bits[142] == block_out.half && block_out.coded_len == 8'hb0)
        else $error("bad half flag");
    AST_HALF_SEQ: assert property (block_valid_out && block_ready_in &&
        block_out.pre_len == 8'h4c && !block_out.half |=> block_valid_out && block_out.half)
        else $error("second half not back to back");
    AST_TAIL_ZERO: assert property (block_valid_out |->
        (block_out.bits << block_out.pre_len) == 143'h0) else $error("bits past length");
    AST_WAKE: assert property (wake_valid_out |->
        block_valid_out && block_out.pre_len == 8'h7c) else $error("stray wake id");
endmodule
bind lcaf_framer lcaf_framer_chk u_chk (.ref_clk_in, .sys_rst_in, .unit_valid_in,
    .unit_ready_out, .block_out, .block_valid_out, .block_ready_in, .wake_valid_out);

// *** verification/testbench.sv ***
// Self-checking bench for the framer: register bus, unit stream, blocks.
// Assumes the block sink model and the bound checker.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] c;
        logic [1:0] k;
        logic [7:0] s;
        logic pr;
        logic rr;
    } lcaf_row_type;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0;
    logic rrd = 1'b0, uv = 1'b0, pr = 1'b0, rq = 1'b0, stall = 1'b0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h0;
    lcaf_pkg::lcaf_unit_type ui = '0;
    logic awr, wr_o, bv, arr, rv, ur, bkv, bkr, wkv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] wkl;
    logic [130:0] u;
    lcaf_pkg::lcaf_block_type blk;
    int failures = 0, total_checks = 0, cyc = 0, i;
    lcaf_row_type rows [8] = '{{8'h01, 2'h0, 8'h11, 2'b10}, {8'h09, 2'h0, 8'h12, 2'b01},
        {8'h03, 2'h0, 8'h13, 2'b11}, {8'h55, 2'h0, 8'h14, 2'b11},
        {8'h01, 2'h1, 8'h15, 2'b11}, {8'h03, 2'h1, 8'h16, 2'b11},
        {8'h01, 2'h2, 8'h17, 2'b01}, {8'h01, 2'h2, 8'h18, 2'b10}};
    lcaf_framer DUT (.ref_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_o),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rrd), .unit_in(ui), .unit_valid_in(uv), .unit_ready_out(ur),
        .pwr_reduce_policy_in(pr), .robust_req_policy_in(rq), .block_out(blk),
        .block_valid_out(bkv), .block_ready_in(bkr), .wake_link_identifier_out(wkl),
        .wake_valid_out(wkv));
    lcaf_block_sink SNK (.ref_clk_in(clk), .sys_rst_in(rst), .block_in(blk),
        .block_valid_in(bkv), .wake_in(wkl), .wake_valid_in(wkv), .stall_in(stall),
        .block_ready_out(bkr));
    // ----
    // Helpers.
    // ----
    initial forever #12.5 clk = ~clk;
    task conclude;
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude;
        end
    end
    task cmp(input logic [159:0] g, input logic [159:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, tb;
        logic [1:0] r;
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wr_o;
            tb = bv;
            r = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        br <= 1'b0;
        @(posedge clk);
        cmp(160'(r), 160'(e));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
        logic ta, tb;
        logic [33:0] g;
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do begin
            @(negedge clk);
            ta = arv && arr;
            tb = rv;
            g = {rdata, rresp};
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end while (!tb);
        rrd <= 1'b0;
        @(posedge clk);
        cmp(160'(g), 160'({ed, e}));
    endtask
    task send(input lcaf_pkg::lcaf_unit_type v, input logic p, input logic q, input logic fin);
        logic t;
        ui <= v;
        pr <= p;
        rq <= q;
        uv <= 1'b1;
        do begin
            @(negedge clk);
            t = ur;
            @(posedge clk);
        end while (!t);
        if (fin) uv <= 1'b0;
    endtask
    task await_blocks(input int n);
        while (SNK.got.size() < n) @(posedge clk);
        @(posedge clk);
    endtask
    function automatic logic [130:0] mku(input logic [1:0] k, input logic [7:0] s);
        logic [130:0] v;
        int j;
        v = {14'h2a5c ^ {6'h0, s}, s[4:0], {14{s}}};
        if (k != 2'h0) begin
            v = '0;
            for (j = 0; j < 6; j++) v[125 - 21 * j -: 21] = {s, 6'(j), 2'(j), 5'(s) + 5'(j)};
            if (k == 2'h2) v = {89'h0, v[125:84]};
        end
        return v;
    endfunction
    function automatic lcaf_pkg::lcaf_block_type exp_blk(input logic [7:0] c,
        input logic [1:0] k, input logic [130:0] v, input logic p, input logic q);
        lcaf_pkg::lcaf_block_type b;
        logic f1, f2;
        int j;
        b = '0;
        f1 = p && c[2:1] == 2'h0;
        f2 = q && c[2:1] == 2'h0;
        if (k == 2'h0 && c[2:1] != 2'h2) begin
            b.bits = {7'h0, v[116:0], 19'h0};
            b.pre_len = 8'h7c;
            b.coded_len = c[3] ? 8'hfc : 8'ha8;
        end else if (k == 2'h0) begin
            b.bits = {1'b1, c[7:4], v, 7'h0};
            b.pre_len = 8'h88;
            b.coded_len = 8'hb0;
        end else begin
            for (j = 0; j < 6; j++) b.bits[137 - 23 * j -: 23] = {v[125 - 21 * j -: 21], f1, f2};
            b.pre_len = 8'h8f;
            b.coded_len = 8'haf;
            if (k == 2'h2) b.bits = {5'h0, v[41:21], f1, f2, v[20:0], f1, f2, 92'h0};
            if (k == 2'h2) b.pre_len = 8'h33;
        end
        return b;
    endfunction
    function automatic logic [13:0] crc14(input logic [130:0] v);
        logic [13:0] r;
        int j;
        r = 14'h3fff;
        for (j = 130; j >= 0; j--) r = {r[12:0], 1'b0} ^ ((r[13] ^ v[j]) ? 14'h0443 : 14'h0);
        return ~r;
    endfunction
    // ----
    // Sequence.
    // ----
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h1, 2'h0);
        wr(8'h10, 32'h1, 2'h2);
        rd(8'h0c, 32'h0, 2'h2);
        for (i = 0; i < 8; i++) begin
            wr(8'h00, {24'h0, rows[i].c}, 2'h0);
            u = mku(rows[i].k, rows[i].s);
            send({rows[i].k, u}, rows[i].pr, rows[i].rr, 1'b1);
            await_blocks(1);
            cmp(SNK.got.pop_front(), exp_blk(rows[i].c, rows[i].k, u, rows[i].pr, rows[i].rr));
            if (rows[i].k == 2'h0 && rows[i].c[2:1] != 2'h2)
                cmp(160'(SNK.wake_seen), 160'(u[130:117]));
        end
        stall <= 1'b1;
        send({2'h0, mku(2'h0, 8'h21)}, 1'b0, 1'b0, 1'b0);
        send({2'h0, mku(2'h0, 8'h22)}, 1'b0, 1'b0, 1'b1);
        await_blocks(2);
        for (i = 0; i < 2; i++)
            cmp(SNK.got.pop_front(), exp_blk(8'h01, 2'h0, mku(2'h0, 8'h21 + 8'(i)), 1'b0, 1'b0));
        wr(8'h00, 32'h5d, 2'h0);
        send({2'h0, mku(2'h0, 8'h3c)}, 1'b0, 1'b0, 1'b0);
        send({2'h0, mku(2'h0, 8'h3d)}, 1'b0, 1'b0, 1'b1);
        await_blocks(4);
        for (i = 0; i < 2; i++) begin
            u = mku(2'h0, 8'h3c + 8'(i));
            cmp(SNK.got.pop_front(), {2'b01, 4'h5, u[130:61], 67'h0, 8'h4c, 8'hb0, 1'b0});
            cmp(SNK.got.pop_front(), {1'b1, crc14(u), u[60:0], 67'h0, 8'h4c, 8'hb0, 1'b1});
        end
        rd(8'h08, {18'h0, crc14(u)}, 2'h0);
        rd(8'h00, 32'h5d, 2'h0);
        rd(8'h04, 32'h000c0001, 2'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        cmp(160'(ur), 160'(1'b0));
        @(posedge clk);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h1, 2'h0);
        conclude;
    end
endmodule
